// *** shared/conv_ctrl_defs.svh ***
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a 32-bit AHB-Lite register port with one aligned word per register.
//
// Contract
// R1: Enable bit turns converter on and off.
// R2: Soft reset restores registers except debug control.
// R3: Writing zero to soft reset does nothing.
// R4: Soft reset write discards other written bits.
// R5: Reset completes after sync delay, clears flags.
// R6: Soft reset bit reads one while pending.
// R7: Start by software trigger or automatic trigger.
// R8: Sampling begins only on a conversion trigger.
// R9: Free running restarts after each conversion.
// R10: Each conversion overwrites the result register.
// R11: Unread result with many channels sets overrun.
// R12: Enable-set writes of one enable interrupts.
// R13: Converter clock is input over two power one-plus-prescaler.
// R14: Sampling length field sets sampling cycles.
// R15: Offset compensation phase runs when bit set.
// R16: Conversion takes sampling plus offset plus resolution cycles.
// R17: Flags clear by writing one, zero ignored.
`ifndef CONV_CTRL_DEFS_SVH
`define CONV_CTRL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MAIN_CONTROL_OFS 12'h000
`define INPUT_SELECT_OFS 12'h004
`define SAMPLING_CONTROL_OFS 12'h008
`define SOFTWARE_TRIGGER_OFS 12'h00C
`define INT_ENABLE_CLR_OFS 12'h010
`define INT_ENABLE_SET_OFS 12'h014
`define INT_FLAG_OFS 12'h018
`define SYNC_BUSY_OFS 12'h01C
`define RESULT_OFS 12'h020
`define DEBUG_CONTROL_OFS 12'h024
`define CONFIG_OFS 12'h028

// ****************************************************************
// Field positions
// ****************************************************************
`define MC_SOFT_RESET_POS 0
`define MC_ENABLE_POS 1
`define MC_PRESC_LSB 8
`define SC_OFFSET_COMP_BIT_POS 7
`define SWT_START_POS 1
`define INT_RESULT_READY_FLAG_POS 0
`define INT_OVERRUN_POS 1
`define CFG_FREERUN_POS 0
`define CFG_AUTOTRIG_POS 1
`define CFG_RES8_POS 2
`define CFG_MULTI_POS 3

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define PRESC_RESET 3'h0
`define SAMPLING_LENGTH_FIELD_RESET 6'h00
`define OFFSET_COMP_BIT_CYCLES 5'h04
`define SOFT_RESET_SYNC_CYCLES 3'h3
`define RES_HIGH_BITS 5'h0C
`define RES_LOW_BITS 5'h08

`endif

// *** shared/conv_ctrl_pkg.sv ***
// Types shared by the converter control modules.
// Assumes the constants header supplies all numbers.
package conv_ctrl_pkg;

  // Conversion sequencer phases.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OFFSET_COMP_BIT,
    PH_SAMPLE,
    PH_DATA
  } conv_phase_t;

endpackage

// *** src/conv_prescaler.sv ***
// Converter clock-tick generator from the generic converter clock.
// Assumes clock_i is the generic converter clock; emits one-cycle ticks.
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_defs.svh"

module conv_prescaler #(
  parameter int PW = 3
) (
  input wire logic clock_i, // Generic converter clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic run_i, // Count only while enabled.
  input wire logic [PW-1:0] presc_i, // Prescaler field.
  output logic tick_o // One pulse per converter clock period.
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } presc_state_t;

  presc_state_t cur_ff;
  presc_state_t nxt_ff;
  logic [15:0] limit;

  // ****************************************************************
  // Divide by two to the power of one plus the prescaler field
  // ****************************************************************
  // R13: divider limit
  always_comb
  begin
    // Shifting a two keeps the exponent from wrapping at the top prescaler value.
    limit = (16'h0002 << presc_i) - 16'h0001;
    nxt_ff = cur_ff;
    nxt_ff.tick = 1'b0;
    if (!run_i)
    begin
      nxt_ff.cnt = 16'h0000;
    end
    else if (cur_ff.cnt >= limit)
    begin
      nxt_ff.cnt = 16'h0000;
      nxt_ff.tick = 1'b1;
    end
    else
    begin
      nxt_ff.cnt = cur_ff.cnt + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
  end

  assign tick_o = cur_ff.tick;

endmodule // conv_prescaler

`default_nettype wire

// *** src/conv_sequencer.sv ***
// Conversion phase sequencer: offset compensation, sampling, data bits.
// Assumes ticks mark converter clock periods; analog data arrives at the top on result_data_i.
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_defs.svh"

module conv_sequencer (
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic tick_i, // Converter clock tick.
  input wire logic start_i, // Conversion request, held until accepted.
  input wire logic offset_comp_bit_i, // Offset compensation enable.
  input wire logic [5:0] sampling_length_field_i, // Sampling length field.
  input wire logic res8_i, // Eight-bit resolution select.
  output logic accept_o, // Pulse when a request is taken.
  output logic sampling_o, // High during sample and hold.
  output logic done_o // Pulse at end of conversion.
);

  typedef struct packed {
    conv_ctrl_pkg::conv_phase_t ph;
    logic [6:0] cnt;
    logic acc;
    logic done;
  } seq_state_t;

  seq_state_t cur_ff;
  seq_state_t nxt_ff;

  // ****************************************************************
  // Phase machine, advanced once per converter clock tick
  // ****************************************************************
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.acc = 1'b0;
    nxt_ff.done = 1'b0;
    case (cur_ff.ph)
      conv_ctrl_pkg::PH_IDLE:
      begin
        // R8: sample only on trigger
        if (start_i && tick_i)
        begin
          nxt_ff.acc = 1'b1;
          nxt_ff.cnt = 7'h00;
          // R15: offset phase first
          nxt_ff.ph = offset_comp_bit_i ? conv_ctrl_pkg::PH_OFFSET_COMP_BIT : conv_ctrl_pkg::PH_SAMPLE;
        end
      end
      conv_ctrl_pkg::PH_OFFSET_COMP_BIT:
      begin
        if (tick_i)
        begin
          nxt_ff.cnt = cur_ff.cnt + 7'h01;
          if (cur_ff.cnt == 7'({2'b00, `OFFSET_COMP_BIT_CYCLES} - 7'h01))
          begin
            nxt_ff.cnt = 7'h00;
            nxt_ff.ph = conv_ctrl_pkg::PH_SAMPLE;
          end
        end
      end
      conv_ctrl_pkg::PH_SAMPLE:
      begin
        // R14: sampling length in ticks
        if (tick_i)
        begin
          nxt_ff.cnt = cur_ff.cnt + 7'h01;
          if (cur_ff.cnt >= {1'b0, sampling_length_field_i})
          begin
            nxt_ff.cnt = 7'h00;
            nxt_ff.ph = conv_ctrl_pkg::PH_DATA;
          end
        end
      end
      conv_ctrl_pkg::PH_DATA:
      begin
        // R16: one tick per bit
        if (tick_i)
        begin
          nxt_ff.cnt = cur_ff.cnt + 7'h01;
          if (cur_ff.cnt >= 7'({2'b00, res8_i ? `RES_LOW_BITS : `RES_HIGH_BITS} - 7'h01))
          begin
            nxt_ff.cnt = 7'h00;
            nxt_ff.done = 1'b1;
            nxt_ff.ph = conv_ctrl_pkg::PH_IDLE;
            // R9: restart without idle tick
            if (start_i)
            begin
              nxt_ff.acc = 1'b1;
              nxt_ff.ph = offset_comp_bit_i ? conv_ctrl_pkg::PH_OFFSET_COMP_BIT : conv_ctrl_pkg::PH_SAMPLE;
            end
          end
        end
      end
      default:
      begin
        nxt_ff.ph = conv_ctrl_pkg::PH_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cur_ff <= '0;
      cur_ff.ph <= conv_ctrl_pkg::PH_IDLE;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign accept_o = cur_ff.acc;
  assign done_o = cur_ff.done;
  assign sampling_o = (cur_ff.ph == conv_ctrl_pkg::PH_SAMPLE);

endmodule // conv_sequencer

`default_nettype wire

// *** src/conv_ctrl.sv ***
// Converter control top: AHB-Lite registers, triggers, soft reset, result and interrupts.
// Assumes one AHB-Lite master, word accesses, and an analog front end delivering
// a sampled value on result_data_i when the sequencer finishes.
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_defs.svh"

module conv_ctrl #(
  parameter int PRESC_W = 3,
  parameter int DATA_W = 12
) (
  input wire logic clock_i, // System and generic converter clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic hsel_i, // AHB slave select.
  input wire logic [11:0] haddr_i, // AHB byte address.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write when high.
  input wire logic [2:0] hsize_i, // AHB size, word expected.
  input wire logic [31:0] hwdata_i, // AHB write data.
  input wire logic hready_i, // AHB bus ready.
  output logic [31:0] hrdata_o, // AHB read data.
  output logic hreadyout_o, // AHB slave ready.
  output logic hresp_o, // AHB response, always OKAY.
  input wire logic auto_trig_i, // Automatic trigger pulse from event logic.
  input wire logic [DATA_W-1:0] result_data_i, // Value from the analog front end.
  output logic [4:0] chan_sel_o, // Multiplexer channel select.
  output logic sample_o, // Sample and hold active.
  output logic irq_o // Level interrupt.
);

  // Full register state in one struct.
  typedef struct packed {
    logic enable;
    logic [PRESC_W-1:0] presc;
    logic [4:0] chan;
    logic [5:0] sampling_length_field;
    logic offset_comp_bit;
    logic freerun;
    logic autotrig;
    logic res8;
    logic multi;
    logic [1:0] int_en;
    logic [1:0] int_flag;
    logic [DATA_W-1:0] result;
    logic [7:0] dbg;
    logic srst_pend;
    logic [2:0] srst_cnt;
    logic start_pend;
    logic busy;
    logic unread;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic irq;
    logic [4:0] trig_sync;
  } top_state_t;

  top_state_t cur_ff;
  top_state_t nxt_ff;
  logic tick;
  logic accept;
  logic sampling;
  logic done;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic trig_evt;

  // ****************************************************************
  // Converter clock prescaler
  // ****************************************************************
  conv_prescaler #(
    .PW(PRESC_W)
  ) u_presc (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(cur_ff.enable),
    .presc_i(cur_ff.presc),
    .tick_o(tick)
  );

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  conv_sequencer u_seq (
    .clock_i(clock_i),
    .rst_i(rst_i || cur_ff.srst_pend || !cur_ff.enable),
    .tick_i(tick),
    .start_i(cur_ff.start_pend || (cur_ff.busy && cur_ff.freerun)),
    .offset_comp_bit_i(cur_ff.offset_comp_bit),
    .sampling_length_field_i(cur_ff.sampling_length_field),
    .res8_i(cur_ff.res8),
    .accept_o(accept),
    .sampling_o(sampling),
    .done_o(done)
  );

  // Address phase accepted on a selected NONSEQ or SEQ transfer.
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  // Trigger pin passes five flops; rising edge once trig_sync[2] and trig_sync[3] are high and trig_sync[4] is low.
  assign trig_evt = cur_ff.trig_sync[2] && cur_ff.trig_sync[3] && !cur_ff.trig_sync[4];

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr_i == `MAIN_CONTROL_OFS)
    begin
      // R6: pending reset reads one
      rd_mux[`MC_SOFT_RESET_POS] = cur_ff.srst_pend;
      rd_mux[`MC_ENABLE_POS] = cur_ff.enable;
      rd_mux[`MC_PRESC_LSB +: PRESC_W] = cur_ff.presc;
    end
    else if (haddr_i == `INPUT_SELECT_OFS)
      rd_mux[4:0] = cur_ff.chan;
    else if (haddr_i == `SAMPLING_CONTROL_OFS)
    begin
      rd_mux[5:0] = cur_ff.sampling_length_field;
      rd_mux[`SC_OFFSET_COMP_BIT_POS] = cur_ff.offset_comp_bit;
    end
    else if (haddr_i == `INT_ENABLE_CLR_OFS || haddr_i == `INT_ENABLE_SET_OFS)
      rd_mux[1:0] = cur_ff.int_en;
    else if (haddr_i == `INT_FLAG_OFS)
      rd_mux[1:0] = cur_ff.int_flag;
    else if (haddr_i == `SYNC_BUSY_OFS)
      rd_mux[0] = cur_ff.srst_pend;
    else if (haddr_i == `RESULT_OFS)
      rd_mux[DATA_W-1:0] = cur_ff.result;
    else if (haddr_i == `DEBUG_CONTROL_OFS)
      rd_mux[7:0] = cur_ff.dbg;
    else if (haddr_i == `CONFIG_OFS)
    begin
      rd_mux[`CFG_FREERUN_POS] = cur_ff.freerun;
      rd_mux[`CFG_AUTOTRIG_POS] = cur_ff.autotrig;
      rd_mux[`CFG_RES8_POS] = cur_ff.res8;
      rd_mux[`CFG_MULTI_POS] = cur_ff.multi;
    end
  end

  // ****************************************************************
  // Register, trigger and flag logic
  // ****************************************************************
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.trig_sync = {cur_ff.trig_sync[3:0], auto_trig_i};
    nxt_ff.wr_pend = addr_ok && hwrite_i;
    if (addr_ok)
      nxt_ff.wr_addr = haddr_i;
    // Reads are answered one cycle after the address phase, with no wait state.
    if (addr_ok && !hwrite_i)
      nxt_ff.rdata = rd_mux;
    // R7: software or automatic start
    if (trig_evt && cur_ff.autotrig && cur_ff.enable)
      nxt_ff.start_pend = 1'b1;
    if (accept)
      nxt_ff.start_pend = 1'b0;
    // R9: chain free-running conversions
    // A running conversion asks for the next at its last tick, so none is lost.
    if (done)
      nxt_ff.busy = 1'b0;
    if (accept)
      nxt_ff.busy = 1'b1;
    if (!cur_ff.enable || cur_ff.srst_pend)
      nxt_ff.busy = 1'b0;
    // R10: result overwritten
    if (done)
    begin
      nxt_ff.result = result_data_i;
      nxt_ff.unread = 1'b1;
      nxt_ff.int_flag[`INT_RESULT_READY_FLAG_POS] = 1'b1;
      // R11: unread result overruns
      if (cur_ff.unread && cur_ff.multi)
        nxt_ff.int_flag[`INT_OVERRUN_POS] = 1'b1;
    end
    else if (addr_ok && !hwrite_i && haddr_i == `RESULT_OFS)
    begin
      nxt_ff.unread = 1'b0;
    end
    // Data phase of a write; flag clears lose to a same-cycle set above.
    if (cur_ff.wr_pend && !cur_ff.srst_pend)
    begin
      if (cur_ff.wr_addr == `MAIN_CONTROL_OFS)
      begin
        // R4: soft reset wins over the write
        if (hwdata_i[`MC_SOFT_RESET_POS])
        begin
          nxt_ff.srst_pend = 1'b1;
          nxt_ff.srst_cnt = `SOFT_RESET_SYNC_CYCLES;
        end
        // R3: zero soft reset has no effect
        else
        begin
          // R1: enable and disable
          nxt_ff.enable = hwdata_i[`MC_ENABLE_POS];
          nxt_ff.presc = hwdata_i[`MC_PRESC_LSB +: PRESC_W];
        end
      end
      else if (cur_ff.wr_addr == `INPUT_SELECT_OFS)
        nxt_ff.chan = hwdata_i[4:0];
      else if (cur_ff.wr_addr == `SAMPLING_CONTROL_OFS)
      begin
        nxt_ff.sampling_length_field = hwdata_i[5:0];
        nxt_ff.offset_comp_bit = hwdata_i[`SC_OFFSET_COMP_BIT_POS];
      end
      else if (cur_ff.wr_addr == `SOFTWARE_TRIGGER_OFS)
      begin
        if (hwdata_i[`SWT_START_POS] && cur_ff.enable)
          nxt_ff.start_pend = 1'b1;
      end
      else if (cur_ff.wr_addr == `INT_ENABLE_CLR_OFS)
        nxt_ff.int_en = cur_ff.int_en & ~hwdata_i[1:0];
      else if (cur_ff.wr_addr == `INT_ENABLE_SET_OFS)
        // R12: set only ones
        nxt_ff.int_en = cur_ff.int_en | hwdata_i[1:0];
      else if (cur_ff.wr_addr == `INT_FLAG_OFS)
        // R17: write one clears
        nxt_ff.int_flag = nxt_ff.int_flag & ~(hwdata_i[1:0] & ~{done && cur_ff.unread
          && cur_ff.multi, done});
      else if (cur_ff.wr_addr == `DEBUG_CONTROL_OFS)
        nxt_ff.dbg = hwdata_i[7:0];
      else if (cur_ff.wr_addr == `CONFIG_OFS)
      begin
        nxt_ff.freerun = hwdata_i[`CFG_FREERUN_POS];
        nxt_ff.autotrig = hwdata_i[`CFG_AUTOTRIG_POS];
        nxt_ff.res8 = hwdata_i[`CFG_RES8_POS];
        nxt_ff.multi = hwdata_i[`CFG_MULTI_POS];
      end
    end
    // R5: reset completes after sync delay
    if (cur_ff.srst_pend)
    begin
      if (cur_ff.srst_cnt == 3'h0)
      begin
        // R2: all but debug control restored
        nxt_ff = '0;
        nxt_ff.dbg = cur_ff.dbg;
        nxt_ff.trig_sync = cur_ff.trig_sync;
        nxt_ff.presc = `PRESC_RESET;
        nxt_ff.sampling_length_field = `SAMPLING_LENGTH_FIELD_RESET;
      end
      else
      begin
        nxt_ff.srst_cnt = cur_ff.srst_cnt - 3'h1;
      end
    end
    nxt_ff.irq = |(nxt_ff.int_flag & nxt_ff.int_en);
  end

  // State register.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cur_ff <= '0;
      cur_ff.presc <= `PRESC_RESET;
      cur_ff.sampling_length_field <= `SAMPLING_LENGTH_FIELD_RESET;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs from flip-flops; ready and response are constants, sample_o decodes the sequencer phase.
  assign hrdata_o = cur_ff.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign chan_sel_o = cur_ff.chan;
  assign irq_o = cur_ff.irq;
  assign sample_o = sampling;

endmodule // conv_ctrl

`default_nettype wire

// *** tb/conv_front_model.sv ***
// Behavioural analog front end seen by the converter control block.
// Assumes sample_i opens a sampling phase and chan_i is stable then.
`timescale 1ns/1ns
`default_nettype none

module conv_front_model (
  input wire logic clock_i, // Clock.
  input wire logic rst_i, // Reset, active high.
  input wire logic sample_i, // Sample and hold active.
  input wire logic [4:0] chan_i, // Selected channel.
  output logic [11:0] data_o // Held sample value.
);
  logic s_ff;
  logic [6:0] n_ff;

  // value taken at sampling start
  // The held value is the channel and a running count, so a stale result shows.
  always_ff @(posedge clock_i)
  begin
    s_ff <= sample_i;
    if (rst_i)
    begin
      n_ff <= 7'h00;
      data_o <= 12'hFFF;
    end
    else if (sample_i & ~s_ff)
    begin
      n_ff <= n_ff + 7'h01;
      data_o <= {chan_i, n_ff + 7'h01};
    end
  end
endmodule // conv_front_model
`default_nettype wire

// *** tb/conv_ctrl_asserts.sv ***
// Checker for the converter control top: sampling, triggers, reset, irq.
// Assumes word writes, no wait states and a prescaler of two at most.
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_defs.svh"

module conv_ctrl_asserts (
  input wire logic clock_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic hsel_i, // Select.
  input wire logic [11:0] haddr_i, // Address.
  input wire logic [1:0] htrans_i, // Transfer type.
  input wire logic hwrite_i, // Write.
  input wire logic [31:0] hwdata_i, // Write data.
  input wire logic hready_i, // Bus ready.
  input wire logic auto_trig_i, // Automatic trigger.
  input wire logic [4:0] chan_sel_o, // Channel select.
  input wire logic sample_o, // Sampling.
  input wire logic irq_o // Interrupt.
);
  logic wr_ff, en_ff, fr_ff, s_ff, t_ff;
  logic [11:0] ad_ff;
  logic [5:0] sl_ff;
  logic [2:0] ps_ff;
  logic [1:0] ie_ff;
  logic [9:0] hi_ff, gap_ff;
  logic swt;
  logic [9:0] len;

  // A start write opens the window in which sampling may begin.
  assign swt = wr_ff & (ad_ff == `SOFTWARE_TRIGGER_OFS) & hwdata_i[1];
  assign len = ({4'h0, sl_ff} + 10'h001) << ({1'b0, ps_ff} + 4'h1);

  // Shadow of the written settings; soft reset drops the other bits.
  always_ff @(posedge clock_i)
  begin
    wr_ff <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
    ad_ff <= haddr_i;
    s_ff <= sample_o;
    t_ff <= auto_trig_i;
    hi_ff <= sample_o ? hi_ff + 10'h001 : 10'h000;
    gap_ff <= (swt | (auto_trig_i & ~t_ff) | (s_ff & ~sample_o)) ? 10'h000 :
      gap_ff + {9'h000, gap_ff != 10'h3FF};
    if (rst_i)
    begin
      {en_ff, fr_ff, sl_ff, ps_ff, ie_ff} <= '0;
    end
    else if (wr_ff)
    begin
      case (ad_ff)
        `MAIN_CONTROL_OFS:
        begin
          en_ff <= hwdata_i[1] & ~hwdata_i[0];
          ps_ff <= hwdata_i[0] ? 3'h0 : hwdata_i[10:8];
          fr_ff <= fr_ff & ~hwdata_i[0];
        end
        `SAMPLING_CONTROL_OFS: sl_ff <= hwdata_i[5:0];
        `CONFIG_OFS: fr_ff <= hwdata_i[0];
        `INT_ENABLE_SET_OFS: ie_ff <= ie_ff | hwdata_i[1:0];
        `INT_ENABLE_CLR_OFS: ie_ff <= ie_ff & ~hwdata_i[1:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_samp_len;
    $fell(sample_o) |-> hi_ff == len;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
  property p_presc;
    $rose(sample_o) |-> sample_o [*2];
  endproperty
  a_presc: assert property (p_presc) else $error("sampling shorter than a tick");
  property p_dis;
    !en_ff && !sample_o |=> !sample_o;
  endproperty
  a_dis: assert property (p_dis) else $error("sampling while disabled");
  property p_srst;
    wr_ff && ad_ff == `MAIN_CONTROL_OFS && hwdata_i[0] |-> ##[1:8] chan_sel_o == 5'h00;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset kept channel");
  property p_zero;
    wr_ff && ad_ff == `MAIN_CONTROL_OFS && !hwdata_i[0] |-> ##5 $stable(chan_sel_o);
  endproperty
  a_zero: assert property (p_zero) else $error("zero reset write acted");
  property p_trig;
    $rose(sample_o) |-> gap_ff < 10'h12C;
  endproperty
  a_trig: assert property (p_trig) else $error("sampling without trigger");
  property p_irq;
    irq_o |-> ie_ff != 2'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq with no source enabled");
  property p_free;
    fr_ff && en_ff && $fell(sample_o) |-> ##[10:600] $rose(sample_o);
  endproperty
  a_free: assert property (p_free) else $error("free run did not restart");
endmodule // conv_ctrl_asserts

bind conv_ctrl conv_ctrl_asserts chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .auto_trig_i(auto_trig_i), .chan_sel_o(chan_sel_o),
  .sample_o(sample_o), .irq_o(irq_o)
);
`default_nettype wire

// *** tb/adc_conversion_control_tb.sv ***
// Self-checking bench for the converter control block over AHB-Lite.
// Assumes the front end model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_defs.svh"

module adc_conversion_control_tb;
  logic clock_i, rst_i, hsel_i, hwrite_i, auto_trig_i;
  logic [11:0] haddr_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i, hrdata_o, q;
  logic [11:0] result_data_i;
  logic [4:0] chan_sel_o;
  logic hreadyout_o, hresp_o, sample_o, irq_o;
  int err_total, tests_run, cyc, gap;

  conv_ctrl #(.PRESC_W(3), .DATA_W(12)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .auto_trig_i(auto_trig_i),
    .result_data_i(result_data_i), .chan_sel_o(chan_sel_o),
    .sample_o(sample_o), .irq_o(irq_o)
  );
  conv_front_model fm_u (
    .clock_i(clock_i), .rst_i(rst_i), .sample_i(sample_o),
    .chan_i(chan_sel_o), .data_o(result_data_i)
  );

  // Free-running clock of 10 ns.
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under this many cycles.
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // One single word transfer; waits on the slave's ready in both phases.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, q);
    cmp("hresp", 32'h0, {31'h0, hresp_o});
  endtask

  task automatic cirq(input logic e);
    repeat (2) @(negedge clock_i);
    cmp("irq", {31'h0, e}, {31'h0, irq_o});
  endtask

  task automatic wirq;
    do @(negedge clock_i); while (irq_o !== 1'b1);
  endtask

  // Counts clocks up to the next rise of sampling, crossing a high phase first.
  task automatic wrise;
    gap = 0;
    do begin @(negedge clock_i); gap++; end while (sample_o !== 1'b0);
    do begin @(negedge clock_i); gap++; end while (sample_o !== 1'b1);
  endtask

  task automatic wfall;
    do @(negedge clock_i); while (sample_o !== 1'b0);
  endtask

  // The first two rises settle any change made in mid-conversion.
  task automatic per(input int e);
    wrise();
    wrise();
    wrise();
    cmp("period", 32'(e), 32'(gap));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_i, hsel_i, hwrite_i, auto_trig_i} = 4'h8;
    {haddr_i, htrans_i, hwdata_i} = '0;
    hsize_i = 3'h2;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rc(`MAIN_CONTROL_OFS, 32'h0);
    rc(12'h03C, 32'h0);
    wr(`INPUT_SELECT_OFS, 32'h5);
    wr(`SAMPLING_CONTROL_OFS, 32'h1);
    wr(`MAIN_CONTROL_OFS, 32'h2);
    wr(`INT_ENABLE_SET_OFS, 32'h1);
    wr(`INT_ENABLE_SET_OFS, 32'h0);
    wr(`SOFTWARE_TRIGGER_OFS, 32'h2);
    wirq();
    rc(`RESULT_OFS, 32'h281);
    wr(`INT_ENABLE_CLR_OFS, 32'h1);
    cirq(1'b0);
    wr(`INT_ENABLE_SET_OFS, 32'h1);
    cirq(1'b1);
    wr(`INT_FLAG_OFS, 32'h0);
    rc(`INT_FLAG_OFS, 32'h1);
    wr(`INT_FLAG_OFS, 32'h1);
    cirq(1'b0);
    wr(`INPUT_SELECT_OFS, 32'h9);
    wr(`SOFTWARE_TRIGGER_OFS, 32'h2);
    wirq();
    rc(`RESULT_OFS, 32'h482);
    wr(`INT_FLAG_OFS, 32'h1);
    // Two results left unread with several channels on; the second by event.
    wr(`CONFIG_OFS, 32'hA);
    wr(`SOFTWARE_TRIGGER_OFS, 32'h2);
    wrise();
    wfall();
    repeat (40) @(posedge clock_i);
    auto_trig_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    auto_trig_i <= 1'b0;
    wrise();
    wfall();
    repeat (40) @(negedge clock_i);
    rc(`INT_FLAG_OFS, 32'h3);
    wr(`INT_FLAG_OFS, 32'h3);
    rc(`INT_FLAG_OFS, 32'h0);
    // Free-running periods for both resolutions, prescaler fields 0 and 1, and compensation.
    wr(`CONFIG_OFS, 32'h1);
    wr(`SOFTWARE_TRIGGER_OFS, 32'h2);
    per((2 + 12) * 2);
    wfall();
    wr(`CONFIG_OFS, 32'h5);
    per((2 + 8) * 2);
    wfall();
    wr(`CONFIG_OFS, 32'h1);
    wr(`MAIN_CONTROL_OFS, 32'h102);
    per((2 + 12) * 4);
    wfall();
    wr(`SAMPLING_CONTROL_OFS, 32'h80);
    per((4 + 1 + 12) * 4);
    wfall();
    wr(`SAMPLING_CONTROL_OFS, 32'h1);
    wrise();
    wr(`CONFIG_OFS, 32'h0);
    repeat (80) @(negedge clock_i);
    // Soft reset with the enable bit in the same write.
    wr(`DEBUG_CONTROL_OFS, 32'hA5);
    wr(`INPUT_SELECT_OFS, 32'h3);
    wr(`MAIN_CONTROL_OFS, 32'h0);
    rc(`INPUT_SELECT_OFS, 32'h3);
    wr(`MAIN_CONTROL_OFS, 32'h3);
    rc(`MAIN_CONTROL_OFS, 32'h1);
    repeat (10) @(negedge clock_i);
    rc(`MAIN_CONTROL_OFS, 32'h0);
    rc(`SYNC_BUSY_OFS, 32'h0);
    rc(`INPUT_SELECT_OFS, 32'h0);
    rc(`DEBUG_CONTROL_OFS, 32'hA5);
    wr(`SOFTWARE_TRIGGER_OFS, 32'h2);
    repeat (60) @(negedge clock_i);
    rc(`INT_FLAG_OFS, 32'h0);
    summarize();
  end
endmodule // adc_conversion_control_tb
`default_nettype wire
